// ===== src/urab_top.sv
// Serial port with fractional and integer rate dividers, autobaud, flow control, DMA and RS-485 support.
//
// The APB register port and the address map are this design's own decisions.
module urab_top
  import urab_pkg::*;
(
  input  wire logic        mclk,        // Peripheral clock.
  input  wire logic        rstn,        // Asynchronous reset, active low.
  input  wire logic        psel,        // APB select.
  input  wire logic        penable,     // APB access phase.
  input  wire logic        pwrite,      // APB direction.
  input  wire logic [7:0]  paddr,       // APB byte address.
  input  wire logic [31:0] pwdata,      // APB write data.
  output logic      [31:0] prdata,      // APB read data.
  output logic             pready,      // APB ready.
  output logic             pslverr,     // APB error for unmapped offsets.
  input  wire logic        rxd,         // Serial receive line.
  output logic             txd,         // Serial transmit line.
  input  wire logic        cts_n,       // Clear to send, active low.
  output logic             rts_pin,     // Request to send or drive enable.
  input  wire logic        sclk_in,     // Synchronous clock from a master.
  output logic             sclk_out,    // Synchronous clock when master.
  output logic             sclk_oe,     // Drive enable of the clock pin.
  output logic             tx_dma_req,  // Transmit DMA request.
  input  wire logic        tx_dma_ack,  // Transmit DMA acknowledge pulse.
  output logic             rx_dma_req,  // Receive DMA request.
  input  wire logic        rx_dma_ack   // Receive DMA acknowledge pulse.
);
  import urab_pkg::*;

  // The whole state of the block lives in one packed record.
  typedef struct packed {
    logic [7:0]  cfg;        // Configuration bits.
    logic [2:0]  ctl;        // Control bits.
    logic [15:0] integer_rate_divider;        // Integer rate divider value.
    logic [3:0]  oversample_select;        // Oversample count field.
    logic [7:0]  staddr;     // Station address.
    logic [7:0]  frac_num;   // Fraction numerator.
    logic [8:0]  frac_acc;   // Fractional accumulator.
    logic [15:0] div_cnt;    // Integer divider count.
    logic [8:0]  tx_buf;     // Transmit holding word.
    logic        tx_full;    // Holding word is occupied.
    urab_tx_e    tx_st;      // Transmit state.
    logic [3:0]  tx_phase;   // Base clocks within a transmit bit.
    logic [3:0]  tx_bit;     // Transmit data bit index.
    logic [8:0]  tx_sh;      // Transmit shifter.
    urab_rx_e    rx_st;      // Receive state.
    logic [3:0]  rx_phase;   // Base clocks within a receive bit.
    logic [3:0]  rx_bit;     // Receive data bit index.
    logic [8:0]  rx_sh;      // Receive shifter.
    logic [1:0]  rx_smp;     // First two of the three samples.
    logic        rx_bad;     // Noise seen in the current character.
    logic [8:0]  rx_data;    // Last accepted character.
    logic        rx_noise;   // Noise flag of that character.
    logic        rx_ready;   // Receive ready flag.
    logic        noise_flag; // Sticky received noise flag.
    logic        ab_err;     // Sticky rate detect error.
    logic [15:0] ab_units;   // Autobaud bit units counted.
    logic [3:0]  ab_sub;     // Autobaud unsuppressed input clocks within a unit.
    logic        cts_prev;   // Previous clear to send level.
    logic        cts_chg;    // Clear to send change flag.
    logic        sclk_prev;  // Previous external clock level.
    logic        txd;        // Registered transmit line.
    logic        rts_pin;    // Registered request to send pin.
    logic        sclk_out;   // Registered clock output.
    logic        tx_req;     // Registered transmit request.
    logic        rx_req;     // Registered receive request.
    logic [31:0] prdata;     // Read data captured in setup.
  } urab_state_s;

  urab_state_s s;          // Current state.
  urab_state_s next_s;     // Next state.
  logic        frac_pulse; // Input clock not suppressed.
  logic        base_tick;  // Integer divider output pulse.
  logic        bit_clk;    // One oversample or one sync bit clock.
  logic        sync;       // Synchronous mode.
  logic [3:0]  os_n;       // Last phase of a bit.
  logic [3:0]  mid;        // Centre sample phase.
  logic [3:0]  last_bit;   // Index of the last data bit.
  logic        at_vote;    // Third sample is being taken.
  logic [2:0]  v3;         // The three samples.
  logic        maj;        // Majority value.
  logic        dis;        // Samples disagree.
  logic        hit;        // Address is mapped.
  logic [31:0] rdata;      // Read mux output.
  logic        accept;     // Character passes station filtering.
  logic [8:0]  rx_word;    // Character aligned to bit zero.

  assign pready     = 1'b1;
  assign pslverr    = psel & penable & ~hit;
  assign prdata     = s.prdata;
  assign txd        = s.txd;
  assign rts_pin    = s.rts_pin;
  assign sclk_out   = s.sclk_out;
  assign sclk_oe    = s.cfg[CFG_SYNC] & s.cfg[CFG_MASTER];
  assign tx_dma_req = s.tx_req;
  assign rx_dma_req = s.rx_req;

  // Next state: bus access first, hardware events last so that a set beats a clear in the same cycle.
  always_comb begin
    next_s = s;
    // An input clock passes while the accumulator is below 256, each pass adds the numerator.
    frac_pulse = ~s.frac_acc[8];
    base_tick  = frac_pulse && (s.div_cnt == s.integer_rate_divider);
    sync       = s.cfg[CFG_SYNC];
    // Sync master shifts on every base tick, slave on the external clock rise.
    if (sync) begin
      bit_clk = s.cfg[CFG_MASTER] ? base_tick : (sclk_in & ~s.sclk_prev);
    end else begin
      bit_clk = base_tick;
    end
    os_n     = sync ? 4'h0 : s.oversample_select;
    mid      = 4'((5'(s.oversample_select) + 5'h01) >> 1);
    last_bit = s.ctl[CTL_DETECT] ? LAST_BIT9 : LAST_BIT8;
    at_vote  = sync | (s.rx_phase == 4'(mid + 4'h1));
    v3       = sync ? {3{rxd}} : {s.rx_smp, rxd};
    maj      = (v3[0] & v3[1]) | (v3[0] & v3[2]) | (v3[1] & v3[2]);
    dis      = (|v3) & ~(&v3);
    rx_word  = s.ctl[CTL_DETECT] ? s.rx_sh : {1'b0, s.rx_sh[8:1]};
    // Data characters are dropped in detect mode; address characters may be matched in hardware.
    accept   = ~s.ctl[CTL_DETECT] |
               (rx_word[8] & (~s.cfg[CFG_HWMATCH] | (rx_word[7:0] == s.staddr)));

    // Read mux.
    hit = 1'b1;
    case (paddr)
      ADDR_CFG:    rdata = 32'(s.cfg);
      ADDR_CTL:    rdata = 32'(s.ctl);
      ADDR_STAT:   rdata = 32'({s.ab_err, s.noise_flag, (s.ctl[CTL_TRANSMIT_DISABLE] && s.tx_st == TX_IDLE),
                                s.cts_chg, cts_n, ~s.tx_full, s.rx_ready});
      ADDR_RECEIVE_DATA_REGISTER:  rdata = 32'(s.rx_data);
      ADDR_RXSTAT: rdata = 32'({s.rx_noise, 7'h00, s.rx_data});
      ADDR_TXDAT:  rdata = 32'(s.tx_buf);
      ADDR_BRG:    rdata = 32'(s.integer_rate_divider);
      ADDR_OSR:    rdata = 32'(s.oversample_select);
      ADDR_STADDR: rdata = 32'(s.staddr);
      ADDR_FRAC:   rdata = 32'(s.frac_num);
      default: begin
        rdata = 32'h00000000;
        hit   = 1'b0;
      end
    endcase
    // Read data is captured in the setup cycle so it comes from a flip-flop in the access phase.
    if (psel && !penable) begin
      next_s.prdata = rdata;
    end

    // Register writes take effect at the end of the access phase.
    if (psel && penable && pwrite) begin
      case (paddr)
        ADDR_CFG:    next_s.cfg = pwdata[7:0];
        ADDR_CTL:    next_s.ctl = pwdata[2:0];
        ADDR_STAT: begin
          // Write one to clear the sticky flags.
          if (pwdata[ST_CTSCHG]) next_s.cts_chg = 1'b0;
          if (pwdata[ST_NOISE])  next_s.noise_flag = 1'b0;
          if (pwdata[ST_RATE_DETECT_ERROR])  next_s.ab_err = 1'b0;
        end
        ADDR_TXDAT: begin
          // A write to a full holding word is dropped.
          if (!s.tx_full) begin
            next_s.tx_buf  = pwdata[8:0];
            next_s.tx_full = 1'b1;
          end
        end
        ADDR_BRG:    next_s.integer_rate_divider = pwdata[15:0];
        ADDR_OSR:    next_s.oversample_select = pwdata[3:0];
        ADDR_STADDR: next_s.staddr = pwdata[7:0];
        ADDR_FRAC:   next_s.frac_num = pwdata[7:0];
        default:     next_s.cfg = s.cfg;
      endcase
    end
    // Reading the receive data consumes the character.
    if (psel && penable && !pwrite && paddr == ADDR_RECEIVE_DATA_REGISTER) begin
      next_s.rx_ready = 1'b0;
    end

    // Fractional divider spreads the suppressed clocks evenly.
    if (s.frac_acc[8]) begin
      next_s.frac_acc = s.frac_acc - FRAC_WRAP;
    end else begin
      next_s.frac_acc = s.frac_acc + {1'b0, s.frac_num};
    end
    // Integer divider counts unsuppressed clocks.
    if (frac_pulse) begin
      next_s.div_cnt = base_tick ? 16'h0000 : s.div_cnt + 16'h0001;
    end

    // Transmitter. New characters start only on a bit clock and only when allowed.
    if (s.tx_st == TX_IDLE) begin
      next_s.txd = 1'b1;
      if (bit_clk && s.tx_full && s.cfg[CFG_ENABLE] && !s.ctl[CTL_TRANSMIT_DISABLE]
          && (!s.cfg[CFG_CTSEN] || !cts_n)) begin
        next_s.tx_sh    = s.tx_buf;
        next_s.tx_full  = 1'b0;
        next_s.tx_st    = TX_START;
        next_s.tx_phase = 4'h0;
        next_s.txd      = 1'b0;
      end
    end else if (bit_clk) begin
      if (s.tx_phase != os_n) begin
        next_s.tx_phase = s.tx_phase + 4'h1;
      end else begin
        next_s.tx_phase = 4'h0;
        case (s.tx_st)
          TX_START: begin
            next_s.tx_st  = TX_DATA;
            next_s.tx_bit = 4'h0;
            next_s.txd    = s.tx_sh[0];
          end
          TX_DATA: begin
            if (s.tx_bit == last_bit) begin
              next_s.tx_st = TX_STOP;
              next_s.txd   = 1'b1;
            end else begin
              next_s.tx_bit = s.tx_bit + 4'h1;
              next_s.tx_sh  = {1'b0, s.tx_sh[8:1]};
              next_s.txd    = s.tx_sh[1];
            end
          end
          // The optional turnaround keeps the drive enable one more bit time.
          TX_STOP: next_s.tx_st = s.cfg[CFG_DETA] ? TX_TURN : TX_IDLE;
          default: next_s.tx_st = TX_IDLE;
        endcase
      end
    end

    // Receiver.
    case (s.rx_st)
      RX_IDLE: begin
        if (s.cfg[CFG_ENABLE] && s.ctl[CTL_AUTOBD] && !sync) begin
          if (!rxd) begin
            // Start bit begins; count it in whole bit units, rounded by a half-unit preload.
            next_s.rx_st    = RX_AB_MEAS;
            next_s.ab_units = 16'h0000;
            next_s.ab_sub   = mid;
          end
        end else if (s.cfg[CFG_ENABLE] && bit_clk && !rxd) begin
          next_s.rx_st    = sync ? RX_DATA : RX_START;
          next_s.rx_phase = sync ? 4'h0 : 4'h1;
          next_s.rx_bit   = 4'h0;
          next_s.rx_bad   = 1'b0;
        end
      end
      RX_AB_MEAS: begin
        if (frac_pulse) begin
          // Units follow the current fractional and oversample settings.
          if (s.ab_sub == s.oversample_select) begin
            next_s.ab_sub   = 4'h0;
            next_s.ab_units = s.ab_units + 16'h0001;
          end else begin
            next_s.ab_sub = s.ab_sub + 4'h1;
          end
        end
        if (rxd) begin
          // Rising edge ends the start bit; the rest of the character is received normally.
          next_s.integer_rate_divider      = (s.ab_units == 16'h0000) ? 16'h0000 : s.ab_units - 16'h0001;
          next_s.div_cnt  = 16'h0000;
          next_s.rx_st    = RX_DATA;
          next_s.rx_phase = 4'h0;
          next_s.rx_bit   = 4'h0;
          next_s.rx_bad   = 1'b0;
        end else if (s.ab_units == AB_TIMEOUT) begin
          next_s.ab_err = 1'b1;
          next_s.rx_st  = RX_AB_ERR;
        end
      end
      RX_AB_ERR: begin
        // Autobaud stays enabled until the line is idle again.
        if (rxd) begin
          next_s.ctl[CTL_AUTOBD] = 1'b0;
          next_s.rx_st           = RX_IDLE;
        end
      end
      default: begin
        if (bit_clk) begin
          // First two samples are held one phase before the centre and at the centre phase.
          if (s.rx_phase == 4'(mid - 4'h1) || s.rx_phase == mid) begin
            next_s.rx_smp = {s.rx_smp[0], rxd};
          end
          if (at_vote && s.rx_st == RX_STOP) begin
            next_s.rx_st = RX_IDLE;
            if (accept) begin
              next_s.rx_data    = rx_word;
              next_s.rx_noise   = s.rx_bad | dis;
              next_s.noise_flag = s.noise_flag | s.rx_bad | dis;
              next_s.rx_ready   = 1'b1;
              next_s.ctl[CTL_AUTOBD] = 1'b0;
            end
          end else if (at_vote && s.rx_st == RX_START && maj) begin
            // A start bit that does not hold low is a glitch.
            next_s.rx_st = RX_IDLE;
          end else begin
            if (at_vote) begin
              next_s.rx_bad = s.rx_bad | dis;
              if (s.rx_st == RX_DATA) begin
                next_s.rx_sh = {maj, s.rx_sh[8:1]};
              end
            end
            if (s.rx_phase != os_n) begin
              next_s.rx_phase = s.rx_phase + 4'h1;
            end else begin
              next_s.rx_phase = 4'h0;
              if (s.rx_st == RX_START) begin
                next_s.rx_st = RX_DATA;
              end else if (s.rx_bit == last_bit) begin
                next_s.rx_st = RX_STOP;
              end else begin
                next_s.rx_bit = s.rx_bit + 4'h1;
              end
            end
          end
        end
      end
    endcase

    // Clear to send change detection wins over a software clear.
    next_s.cts_prev = cts_n;
    if (cts_n != s.cts_prev) begin
      next_s.cts_chg = 1'b1;
    end
    next_s.sclk_prev = sclk_in;
    next_s.sclk_out  = sync & s.cfg[CFG_MASTER] & base_tick;
    // Drive enable while a character is on the line, else request to send follows the receive ready flag.
    // The enable follows the next transmit state, so it asserts with the start bit and the line never floats under it.
    if (s.cfg[CFG_DESEL]) begin
      next_s.rts_pin = (next_s.tx_st != TX_IDLE) ^ ~s.cfg[CFG_DEPOL];
    end else begin
      next_s.rts_pin = s.rx_ready;
    end
    // Requests drop for one cycle on an acknowledge so a serviced request is not seen twice.
    next_s.tx_req = ~s.tx_full & s.cfg[CFG_ENABLE] & ~tx_dma_ack;
    next_s.rx_req = s.rx_ready & ~rx_dma_ack;
  end

  // State register; every field resets to a constant.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s          <= '0;
      s.cfg      <= CFG_RESET;
      s.ctl      <= CTL_RESET;
      s.integer_rate_divider      <= BRG_RESET;
      s.oversample_select      <= OSR_RESET;
      s.staddr   <= STADDR_RESET;
      s.frac_num <= FRAC_RESET;
      s.tx_st    <= TX_IDLE;
      s.rx_st    <= RX_IDLE;
      s.cts_prev <= 1'b1;
      s.txd      <= 1'b1;
      s.rts_pin  <= 1'b0;
    end else begin
      s <= next_s;
    end
  end
endmodule

// ===== src/urab_pkg.sv
// Package with register map, field positions, reset values and state types of the serial port.
package urab_pkg;
  // Register byte offsets on the APB bus.
  localparam logic [7:0] ADDR_CFG    = 8'h00;
  localparam logic [7:0] ADDR_CTL    = 8'h04;
  localparam logic [7:0] ADDR_STAT   = 8'h08;
  localparam logic [7:0] ADDR_RECEIVE_DATA_REGISTER  = 8'h0C;
  localparam logic [7:0] ADDR_RXSTAT = 8'h10;
  localparam logic [7:0] ADDR_TXDAT  = 8'h14;
  localparam logic [7:0] ADDR_BRG    = 8'h18;
  localparam logic [7:0] ADDR_OSR    = 8'h1C;
  localparam logic [7:0] ADDR_STADDR = 8'h20;
  localparam logic [7:0] ADDR_FRAC   = 8'h24;
  // Configuration register bits.
  localparam int CFG_ENABLE  = 0;
  localparam int CFG_SYNC    = 1;
  localparam int CFG_MASTER  = 2;
  localparam int CFG_CTSEN   = 3;
  localparam int CFG_HWMATCH = 4;
  localparam int CFG_DESEL   = 5;
  localparam int CFG_DEPOL   = 6;
  localparam int CFG_DETA    = 7;
  // Control register bits.
  localparam int CTL_TRANSMIT_DISABLE   = 0;
  localparam int CTL_DETECT  = 1;
  localparam int CTL_AUTOBD  = 2;
  // Status register bits.
  localparam int ST_RECEIVE_READY_FLAG    = 0;
  localparam int ST_TXRDY    = 1;
  localparam int ST_CTS      = 2;
  localparam int ST_CTSCHG   = 3;
  localparam int ST_TXOFF    = 4;
  localparam int ST_NOISE    = 5;
  localparam int ST_RATE_DETECT_ERROR    = 6;
  // Position of the noise bit in the receive data with flags register.
  localparam int RXSTAT_NOISE = 16;
  // Reset values.
  localparam logic [7:0]  CFG_RESET    = 8'h00;
  localparam logic [2:0]  CTL_RESET    = 3'h0;
  localparam logic [15:0] BRG_RESET    = 16'h0000;
  localparam logic [3:0]  OSR_RESET    = 4'hF;
  localparam logic [7:0]  STADDR_RESET = 8'h00;
  localparam logic [7:0]  FRAC_RESET   = 8'h00;
  // Fractional accumulator wrap of 256 and autobaud timeout in bit units.
  localparam logic [8:0]  FRAC_WRAP    = 9'h100;
  localparam logic [15:0] AB_TIMEOUT   = 16'hFFFF;
  // Last data bit index for 8-bit and 9-bit characters.
  localparam logic [3:0]  LAST_BIT8    = 4'h7;
  localparam logic [3:0]  LAST_BIT9    = 4'h8;
  // Transmitter and receiver states.
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP, TX_TURN} urab_tx_e;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_AB_MEAS, RX_AB_ERR} urab_rx_e;
endpackage

// ===== dv/urab_props.sv
// Port-level checker for the serial port, bound to its top module.
module urab_props
  import urab_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        txd,
  input wire logic        rts_pin,
  input wire logic        sclk_out,
  input wire logic        sclk_oe,
  input wire logic        tx_dma_req,
  input wire logic        tx_dma_ack,
  input wire logic        rx_dma_req,
  input wire logic        rx_dma_ack
);
  logic [7:0] cfg;  // Shadow of the configuration register, so checks know the mode.
  // Follow configuration writes at the edge where the port takes them.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cfg <= CFG_RESET;
    end else if (psel && penable && pwrite && paddr == ADDR_CFG) begin
      cfg <= pwdata[7:0];
    end
  end
  // All checks run on the port clock and are silenced by reset.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  property p_txack; tx_dma_ack |=> !tx_dma_req; endproperty
  a_txack: assert property (p_txack) else $error("tx request outlived ack");
  property p_rxack; rx_dma_ack |=> !rx_dma_req; endproperty
  a_rxack: assert property (p_rxack) else $error("rx request outlived ack");
  property p_txoff; !$past(cfg[CFG_ENABLE]) |-> !tx_dma_req; endproperty
  a_txoff: assert property (p_txoff) else $error("tx request while disabled");
  property p_de; cfg[CFG_DESEL] && $past(cfg[CFG_DESEL]) && !txd |-> rts_pin == cfg[CFG_DEPOL]; endproperty
  a_de: assert property (p_de) else $error("drive enable off during frame");
  property p_rtsrx; !cfg[CFG_DESEL] && rx_dma_req |-> rts_pin; endproperty
  a_rtsrx: assert property (p_rtsrx) else $error("rts low with data held");
  property p_rtsfall; !cfg[CFG_DESEL] && $fell(rts_pin) |-> !rx_dma_req; endproperty
  a_rtsfall: assert property (p_rtsfall) else $error("rts fell with data held");
  property p_oe; sclk_oe == (cfg[CFG_SYNC] && cfg[CFG_MASTER]); endproperty
  a_oe: assert property (p_oe) else $error("clock pin enable wrong");
  property p_sclk; sclk_out |-> sclk_oe || $past(sclk_oe); endproperty
  a_sclk: assert property (p_sclk) else $error("clock out outside sync master");
endmodule
bind urab_top urab_props props_u (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .txd(txd), .rts_pin(rts_pin), .sclk_out(sclk_out),
  .sclk_oe(sclk_oe), .tx_dma_req(tx_dma_req), .tx_dma_ack(tx_dma_ack), .rx_dma_req(rx_dma_req),
  .rx_dma_ack(rx_dma_ack));

// ===== dv/urab_partner.sv
// Far-side serial device: sends frames on rxd, decodes txd and drives clear to send.
module urab_partner (
  input  wire logic mclk,
  input  wire logic txd,
  output logic      rxd,
  output logic      cts_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int         bit_cyc = 10;  // Clock cycles per bit, set by the bench.
  logic [8:0] got;           // Last character decoded from txd.
  int         n_got = 0;     // Characters decoded so far.
  // The line idles high and the remote starts out holding the port off.
  initial begin
    rxd = 1'b1;
    cts_n = 1'b1;
  end
  // Start, n data bits LSB first, stop; for autobaud the caller keeps bit 0 high.
  task automatic send(input logic [8:0] d, input int n);
    for (int i = -1; i <= n; i++) begin
      rxd <= (i < 0) ? 1'b0 : (i == n) ? 1'b1 : d[i];
      repeat (bit_cyc) @(posedge mclk);
    end
  endtask
  // Sample each bit of a txd frame near its middle.
  always begin
    @(negedge txd);
    repeat (bit_cyc / 2) @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_cyc) @(posedge mclk);
      got[i] = txd;
    end
    got[8] = 1'b0;
    repeat (bit_cyc) @(posedge mclk);
    n_got++;
  end
endmodule

// ===== dv/tb_top.sv
// Self-checking bench: registers, flow control, DMA, autobaud and RS-485 of the serial port.
module tb_top;
  import urab_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, rstn, psel, penable, pwrite, pready, pslverr, txd, rts_pin, rxd, cts_n;
  logic        sclk_out, sclk_oe, tx_dma_req, rx_dma_req, tx_dma_ack, rx_dma_ack, last_err, sclk_in;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_val;
  int          n_fail = 0;
  int          n_checks = 0;
  int          n_sclk = 0;
  urab_top dut_u (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
    .txd(txd), .cts_n(cts_n), .rts_pin(rts_pin), .sclk_in(sclk_in), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
    .tx_dma_req(tx_dma_req), .tx_dma_ack(tx_dma_ack), .rx_dma_req(rx_dma_req), .rx_dma_ack(rx_dma_ack));
  urab_partner partner_u (.mclk(mclk), .txd(txd), .rxd(rxd), .cts_n(cts_n));
  // 200 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic wrap_up();
    if (n_fail == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %0h want %0h", $time, what, got, exp);
    end
  endtask
  // One APB transfer; the idle edge after it keeps back-to-back calls from clashing.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd_val = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h00000000);
    check(rd_val, exp, what);
  endtask
  // Pulse one acknowledge and see its request drop on the next cycle.
  task automatic ack(input bit rx);
    rx_dma_ack <= rx;
    tx_dma_ack <= !rx;
    @(posedge mclk);
    rx_dma_ack <= 1'b0;
    tx_dma_ack <= 1'b0;
    #1 check(32'(rx ? rx_dma_req : tx_dma_req), 32'h00000000, "request after ack");
    @(posedge mclk);
  endtask
  // Cut a hang short; the whole run needs under two thousand cycles.
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    wrap_up();
  end
  initial begin
    {rstn, psel, penable, pwrite, tx_dma_ack, rx_dma_ack, sclk_in} = '0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    rd(ADDR_OSR, 32'h0000000F, "oversample reset");
    rd(ADDR_BRG, 32'h00000000, "divider reset");
    rd(8'hFC, 32'h00000000, "unmapped read");
    check(32'(last_err), 32'h00000001, "unmapped error");
    wr(ADDR_OSR, 32'h00000004);
    wr(ADDR_BRG, 32'h00000001);
    wr(ADDR_CFG, 32'h00000009);
    // The request is registered one edge after the enable lands, so look one edge later.
    @(posedge mclk);
    check(32'(tx_dma_req), 32'h00000001, "tx request");
    ack(1'b0);
    wr(ADDR_TXDAT, 32'h000000A5);
    repeat (40) @(posedge mclk);
    check(32'(txd), 32'h00000001, "txd held off");
    partner_u.cts_n <= 1'b0;
    for (int k = 0; k < 400 && partner_u.n_got < 1; k++) @(posedge mclk);
    check(32'(partner_u.got), 32'h000000A5, "sent char");
    apb(1'b0, ADDR_STAT, 32'h00000000);
    check(32'(rd_val[ST_CTS]), 32'h00000000, "cts level");
    check(32'(rd_val[ST_CTSCHG]), 32'h00000001, "cts change");
    partner_u.send(9'h03C, 8);
    for (int k = 0; k < 400 && rx_dma_req !== 1'b1; k++) @(posedge mclk);
    check(32'(rts_pin), 32'h00000001, "rts with data");
    ack(1'b1);
    rd(ADDR_RECEIVE_DATA_REGISTER, 32'h0000003C, "rx char");
    wr(ADDR_FRAC, 32'h00000080);
    partner_u.bit_cyc = 15;
    partner_u.send(9'h0C3, 8);
    for (int k = 0; k < 400 && rx_dma_req !== 1'b1; k++) @(posedge mclk);
    rd(ADDR_RECEIVE_DATA_REGISTER, 32'h000000C3, "fractional rate char");
    wr(ADDR_FRAC, 32'h00000000);
    wr(ADDR_BRG, 32'h00000000);
    wr(ADDR_CTL, 32'h00000004);
    partner_u.bit_cyc = 20;
    partner_u.send(9'h055, 8);
    for (int k = 0; k < 400 && rx_dma_req !== 1'b1; k++) @(posedge mclk);
    rd(ADDR_BRG, 32'h00000003, "measured divisor");
    rd(ADDR_CTL, 32'h00000000, "autobaud cleared");
    rd(ADDR_RECEIVE_DATA_REGISTER, 32'h00000055, "autobaud char");
    wr(ADDR_STADDR, 32'h00000042);
    wr(ADDR_CFG, 32'h00000011);
    wr(ADDR_CTL, 32'h00000002);
    partner_u.send(9'h143, 9);
    partner_u.send(9'h042, 9);
    repeat (20) @(posedge mclk);
    check(32'(rx_dma_req), 32'h00000000, "foreign chars dropped");
    partner_u.send(9'h142, 9);
    for (int k = 0; k < 400 && rx_dma_req !== 1'b1; k++) @(posedge mclk);
    rd(ADDR_RECEIVE_DATA_REGISTER, 32'h00000142, "own address");
    wr(ADDR_CTL, 32'h00000000);
    wr(ADDR_CFG, 32'h00000061);
    wr(ADDR_TXDAT, 32'h0000005A);
    for (int k = 0; k < 400 && txd !== 1'b0; k++) @(posedge mclk);
    #1 check(32'(rts_pin), 32'h00000001, "drive enable on");
    for (int k = 0; k < 400 && partner_u.n_got < 2; k++) @(posedge mclk);
    check(32'(partner_u.got), 32'h0000005A, "driven char");
    repeat (30) @(posedge mclk);
    check(32'(rts_pin), 32'h00000000, "drive enable off");
    wr(ADDR_CFG, 32'h00000007);
    repeat (20) @(posedge mclk);
    check(32'(sclk_oe), 32'h00000001, "master clock pin");
    // The measured divisor of three gives one clock pulse every four cycles, ten in forty.
    repeat (40) begin
      @(posedge mclk);
      n_sclk += int'(sclk_out);
    end
    check(32'(n_sclk), 32'h0000000A, "master clock pulses");
    // As a synchronous slave the port must wait for the outside clock.
    wr(ADDR_CFG, 32'h00000003);
    wr(ADDR_TXDAT, 32'h00000001);
    repeat (20) @(posedge mclk);
    check(32'(txd), 32'h00000001, "slave waits for clock");
    sclk_in <= 1'b1;
    repeat (2) @(posedge mclk);
    check(32'(txd), 32'h00000000, "slave starts on clock");
    wrap_up();
  end
endmodule
